/* File: bench/mrsx_dmem.sv */
// Data memory partner: one byte per access, written back when the core strobes a write
`timescale 1ns/1ps
module mrsx_dmem (
	// Clock
	input wire logic clk,
	// Access from the bench
	input wire logic take,
	input wire logic [3:0] addr,
	// Core side
	input wire logic mem_we,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [16];
	logic [3:0] wa_ff;
	integer seed;

	initial begin
		seed = 32'h4EBB1062;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'($random(seed));
		end
	end

	// Outside an access the byte lines carry junk, so a late read cannot pass by luck
	assign mem_rdata = take ? mem[addr] : ~mem[addr];

	always @(posedge clk) begin
		if (take) begin
			wa_ff <= addr;
		end
		if (mem_we) begin
			mem[wa_ff] <= mem_wdata;
		end
	end
endmodule

/* File: bench/tb_mcu_rotate_subtract_skip_exec.sv */
// Self-checking bench for the rotate, subtract and skip execution core
`timescale 1ns/1ps
`include "mrsx_consts.svh"
module tb_mcu_rotate_subtract_skip_exec;
	import mrsx_pkg::*;
	logic clk = 0, reset_n = 0, instr_valid = 0, call_req = 0, irq_pending = 0;
	mrsx_op_t instr_op = MRSX_OP_NOP;
	logic [2:0] instr_bit = 0;
	logic [7:0] instr_literal = 0, mem_rdata, mem_wdata, acc;
	logic [12:0] call_target = 0, pc;
	logic [3:0] addr = 0;
	logic mem_we, flag_carry, signed_range_flag, flag_zero, half_carry_flag;
	logic global_irq_enable, busy, irq_taken;
	logic [7:0] macc = 0, mm;
	logic mc = 0, mov = 0, mz = 0, mac = 0, mgie = 0, sk;
	logic [12:0] mpc = 0;
	logic [12:0] mstk[$];
	integer err_count = 0, compares = 0, seed = 32'h4EBB1062;
	mrsx_op_t chain[7] = '{MRSX_OP_SET_BYTE, MRSX_OP_ISZ, MRSX_OP_ISZ, MRSX_OP_DSZ_A,
		MRSX_OP_DSZ, MRSX_OP_DSZ, MRSX_OP_ISZ_A};

	always #2.5 clk = ~clk;

	mrsx_core dut_u (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_bit(instr_bit), .instr_literal(instr_literal),
		.mem_rdata(mem_rdata), .call_target(call_target), .call_req(call_req),
		.irq_pending(irq_pending), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
		.flag_carry(flag_carry), .signed_range_flag(signed_range_flag),
		.flag_zero(flag_zero), .half_carry_flag(half_carry_flag),
		.global_irq_enable(global_irq_enable), .pc(pc), .busy(busy), .irq_taken(irq_taken));

	mrsx_dmem part_u (.clk(clk), .take(instr_valid), .addr(addr), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic ok, input string what);
		compares++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask

	task sub(input logic [7:0] a, input logic [7:0] b, input logic bw, output logic [7:0] r);
		logic [8:0] d;
		logic [4:0] h;
		d = {1'b0, a} - {1'b0, b} - 9'(bw);
		h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bw);
		r = d[7:0];
		mc = ~d[8];
		mac = ~h[4];
		mov = (a[7] != b[7]) && (r[7] != a[7]);
		mz = (r == 8'h00);
	endtask

	task model(input mrsx_op_t op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] lit);
		sk = 1'b0;
		mm = m;
		mpc = mpc + 13'h0001;
		case (op)
			MRSX_OP_RET_LIT: {macc, mpc} = {lit, mstk.pop_back()};
			// A pending request keeps the popped address stacked as its return point
			MRSX_OP_IRQ_EXIT: if (irq_pending) mpc = `MRSX_IRQ_VECTOR;
				else {mgie, mpc} = {1'b1, mstk.pop_back()};
			MRSX_OP_ROL: mm = {m[6:0], m[7]};
			MRSX_OP_ROL_A: macc = {m[6:0], m[7]};
			MRSX_OP_ROLC: {mc, mm} = {m, mc};
			MRSX_OP_ROLC_A: {mc, macc} = {m, mc};
			MRSX_OP_ROR: mm = {m[0], m[7:1]};
			MRSX_OP_ROR_A: macc = {m[0], m[7:1]};
			MRSX_OP_RORC: {mm, mc} = {mc, m};
			MRSX_OP_RORC_A: {macc, mc} = {mc, m};
			MRSX_OP_SBC_A: sub(macc, m, ~mc, macc);
			MRSX_OP_SBC_M: sub(macc, m, ~mc, mm);
			MRSX_OP_DSZ: {sk, mm} = {m == 8'h01, m - 8'h01};
			MRSX_OP_DSZ_A: {sk, macc} = {m == 8'h01, m - 8'h01};
			MRSX_OP_ISZ: {sk, mm} = {m == 8'hFF, m + 8'h01};
			MRSX_OP_ISZ_A: {sk, macc} = {m == 8'hFF, m + 8'h01};
			MRSX_OP_BIT_SKIP: sk = m[b];
			MRSX_OP_SET_BYTE: mm = 8'hFF;
			MRSX_OP_SET_BIT: mm[b] = 1'b1;
			MRSX_OP_SUB_A: sub(macc, m, 1'b0, macc);
			MRSX_OP_SUB_M: sub(macc, m, 1'b0, mm);
			MRSX_OP_SUB_IMM: sub(macc, lit, 1'b0, macc);
			MRSX_OP_SWAP: mm = {m[3:0], m[7:4]};
			default: ;
		endcase
		mpc = mpc + 13'(sk);
	endtask

	// A skipping instruction keeps valid up through the dummy cycle; the core must ignore it
	task run(input mrsx_op_t op, input logic [3:0] a, input logic [2:0] b, input logic [7:0] lit);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		addr <= a;
		instr_bit <= b;
		instr_literal <= lit;
		@(posedge clk);
		model(op, part_u.mem[a], b, lit);
		instr_valid <= sk;
		@(negedge clk);
		check(irq_taken === (op == MRSX_OP_IRQ_EXIT && irq_pending), "interrupt taken");
		check(busy === sk, "dummy cycle after skip");
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
		check(busy === 1'b0, "dummy cycle too long");
		check({acc, flag_carry, signed_range_flag, flag_zero, half_carry_flag, global_irq_enable,
			pc} === {macc, mc, mov, mz, mac, mgie, mpc}, "accumulator, flags or pc");
		check(part_u.mem[a] === mm, "memory byte");
	endtask

	// The core only takes a call in a valid instruction slot
	task call(input logic [12:0] t);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= MRSX_OP_NOP;
		call_req <= 1'b1;
		call_target <= t;
		@(posedge clk);
		instr_valid <= 1'b0;
		call_req <= 1'b0;
		mstk.push_back(mpc + 13'h0001);
		mpc = t;
		@(posedge clk);
	endtask

	initial begin
		#200000;
		err_count++;
		stop_test;
	end

	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check({acc, pc, flag_carry, flag_zero, global_irq_enable, busy, mem_we, irq_taken} === '0,
			"reset values");
		call(13'h0123);
		@(posedge clk) irq_pending <= 1'b1;
		run(MRSX_OP_IRQ_EXIT, 4'h0, 3'h0, 8'h00);
		@(posedge clk) irq_pending <= 1'b0;
		run(MRSX_OP_IRQ_EXIT, 4'h0, 3'h0, 8'h00);
		call(13'h0456);
		run(MRSX_OP_RET_LIT, 4'h0, 3'h0, 8'hA5);
		// Walk one byte through FF, 00, 01 so every skip edge is hit
		foreach (chain[i])
			run(chain[i], 4'h5, 3'h0, 8'h00);
		run(MRSX_OP_SUB_IMM, 4'h0, 3'h0, macc);
		run(MRSX_OP_SUB_IMM, 4'h0, 3'h0, 8'h80);
		repeat (400)
			run(mrsx_op_t'(5'(3 + $unsigned($random(seed)) % 21)), 4'($random(seed)),
				3'($random(seed)), 8'($random(seed)));
		stop_test;
	end
endmodule

/* File: pkg/mrsx_consts.svh */
// Constants of the rotate, subtract and skip execution datapath
// Operation
// RULE1 - Literal return pops PC from stack, loads immediate into accumulator, flags kept.
// RULE2 - Interrupt exit pops PC and sets global interrupt enable, flags kept.
// RULE3 - Interrupt pending at interrupt exit is serviced before main program resumes.
// RULE4 - Rotate left memory: bit 7 into bit 0, written back, no flags.
// RULE5 - Rotate left to accumulator: same rotation into accumulator, memory kept, no flags.
// RULE6 - Rotate left via carry: bit 7 to carry, carry to bit 0, memory.
// RULE7 - Rotate left via carry to accumulator: result in accumulator, carry from bit 7.
// RULE8 - Rotate right memory: bit 0 into bit 7, written back, no flags.
// RULE9 - Rotate right to accumulator: rotation into accumulator, memory kept, no flags.
// RULE10 - Rotate right via carry: bit 0 to carry, carry to bit 7, memory.
// RULE11 - Rotate right via carry to accumulator: result in accumulator, carry from bit 0.
// RULE12 - Subtract with borrow: acc minus mem minus not carry into accumulator, flags update.
// RULE13 - Memory form of subtract with borrow writes difference to memory, same flags.
// RULE14 - Decrement memory, write back, skip next when zero, no flags.
// RULE15 - Decrement to accumulator, memory kept, skip next when zero.
// RULE16 - Increment memory, write back, skip next when zero, no flags.
// RULE17 - Increment to accumulator, memory kept, skip next when zero.
// RULE18 - Conditional skip takes two cycles with a dummy; no skip continues normally.
// RULE19 - Bit test skips next when selected memory bit is nonzero, no flags.
// RULE20 - Byte set writes FFH; bit set forces one bit to 1; no flags.
// RULE21 - Plain subtract into accumulator or memory; carry clear when negative; flags update.
// RULE22 - Immediate subtract into accumulator with same flag rules.
// RULE23 - Nibble swap exchanges low and high nibbles of memory byte.
// RULE24 - Zero flag set on all-zero subtract result; non-skip ops take one cycle.
`ifndef MRSX_CONSTS_SVH
`define MRSX_CONSTS_SVH
`define MRSX_BYTE_ONES 8'hFF
`define MRSX_BYTE_ZERO 8'h00
`define MRSX_ONE 8'h01
`define MRSX_MSB 7
`define MRSX_HC_BIT 4
`define MRSX_PC_RST 13'h0000
`define MRSX_IRQ_VECTOR 13'h0004
`endif

/* File: pkg/mrsx_pkg.sv */
// Types of the rotate, subtract and skip execution datapath
package mrsx_pkg;
	typedef enum logic [4:0] {
		MRSX_OP_NOP = 5'h00,
		MRSX_OP_RET_LIT = 5'h01,
		MRSX_OP_IRQ_EXIT = 5'h02,
		MRSX_OP_ROL = 5'h03,
		MRSX_OP_ROL_A = 5'h04,
		MRSX_OP_ROLC = 5'h05,
		MRSX_OP_ROLC_A = 5'h06,
		MRSX_OP_ROR = 5'h07,
		MRSX_OP_ROR_A = 5'h08,
		MRSX_OP_RORC = 5'h09,
		MRSX_OP_RORC_A = 5'h0A,
		MRSX_OP_SBC_A = 5'h0B,
		MRSX_OP_SBC_M = 5'h0C,
		MRSX_OP_DSZ = 5'h0D,
		MRSX_OP_DSZ_A = 5'h0E,
		MRSX_OP_ISZ = 5'h0F,
		MRSX_OP_ISZ_A = 5'h10,
		MRSX_OP_BIT_SKIP = 5'h11,
		MRSX_OP_SET_BYTE = 5'h12,
		MRSX_OP_SET_BIT = 5'h13,
		MRSX_OP_SUB_A = 5'h14,
		MRSX_OP_SUB_M = 5'h15,
		MRSX_OP_SUB_IMM = 5'h16,
		MRSX_OP_SWAP = 5'h17
	} mrsx_op_t;

	typedef enum logic [1:0] {
		MRSX_ST_EXEC = 2'b00,
		MRSX_ST_DUMMY = 2'b01
	} mrsx_state_t;

	typedef struct packed {
		logic [4:0] opcode;
		logic [2:0] bit_sel;
		logic [7:0] literal;
		logic [7:0] mem_data;
	} mrsx_instr_t;
endpackage

/* File: pkg/mrsx_stack_if.sv */
// Carrier between the core and its return stack
`timescale 1ns/1ps
interface mrsx_stack_if #(parameter int PC_W = 13);
	logic push;
	logic pop;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top_data;
	logic empty;
	modport core (output push, output pop, output push_data, input top_data, input empty);
	modport stack (input push, input pop, input push_data, output top_data, output empty);
endinterface

/* File: src/mrsx_alu.sv */
// Combinational result and flag logic for the rotate, subtract and skip group
`timescale 1ns/1ps
`include "mrsx_consts.svh"
module mrsx_alu (
	// Operands
	input wire mrsx_pkg::mrsx_op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	input wire logic [7:0] literal,
	input wire logic [2:0] bit_sel,
	input wire logic carry_in,
	// Results
	output logic [7:0] result,
	output logic to_acc,
	output logic to_mem,
	output logic carry_we,
	output logic arith_we,
	output logic carry_out,
	output logic ovf_out,
	output logic zero_out,
	output logic half_out,
	output logic skip
);
	import mrsx_pkg::*;
	logic [7:0] sub_b;
	logic borrow_in;
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic [7:0] bit_mask;

	always_comb begin
		bit_mask = `MRSX_ONE << bit_sel;
		// Borrow is the inverted carry only for the with-borrow forms
		borrow_in = ((op == MRSX_OP_SBC_A) || (op == MRSX_OP_SBC_M)) ? ~carry_in : 1'b0;
		sub_b = (op == MRSX_OP_SUB_IMM) ? literal : mem;
		diff = {1'b0, acc} - {1'b0, sub_b} - {8'h00, borrow_in};
		low_diff = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow_in};
		result = acc;
		to_acc = 1'b0;
		to_mem = 1'b0;
		carry_we = 1'b0;
		arith_we = 1'b0;
		carry_out = carry_in;
		skip = 1'b0;
		case (op)
			MRSX_OP_RET_LIT: begin
				result = literal; // see RULE1
				to_acc = 1'b1;
			end
			MRSX_OP_ROL, MRSX_OP_ROL_A: begin
				result = {mem[6:0], mem[`MRSX_MSB]}; // see RULE4 see RULE5
				to_mem = (op == MRSX_OP_ROL);
				to_acc = (op == MRSX_OP_ROL_A);
			end
			MRSX_OP_ROLC, MRSX_OP_ROLC_A: begin
				result = {mem[6:0], carry_in}; // see RULE6 see RULE7
				carry_out = mem[`MRSX_MSB];
				carry_we = 1'b1;
				to_mem = (op == MRSX_OP_ROLC);
				to_acc = (op == MRSX_OP_ROLC_A);
			end
			MRSX_OP_ROR, MRSX_OP_ROR_A: begin
				result = {mem[0], mem[7:1]}; // see RULE8 see RULE9
				to_mem = (op == MRSX_OP_ROR);
				to_acc = (op == MRSX_OP_ROR_A);
			end
			MRSX_OP_RORC, MRSX_OP_RORC_A: begin
				result = {carry_in, mem[7:1]}; // see RULE10 see RULE11
				carry_out = mem[0];
				carry_we = 1'b1;
				to_mem = (op == MRSX_OP_RORC);
				to_acc = (op == MRSX_OP_RORC_A);
			end
			MRSX_OP_SBC_A, MRSX_OP_SBC_M, MRSX_OP_SUB_A, MRSX_OP_SUB_M,
			MRSX_OP_SUB_IMM: begin
				result = diff[7:0]; // see RULE12 see RULE13 see RULE21 see RULE22
				carry_out = ~diff[8];
				carry_we = 1'b1;
				arith_we = 1'b1;
				to_mem = (op == MRSX_OP_SBC_M) || (op == MRSX_OP_SUB_M);
				to_acc = !to_mem;
			end
			MRSX_OP_DSZ, MRSX_OP_DSZ_A: begin
				result = mem - `MRSX_ONE; // see RULE14 see RULE15
				skip = (result == `MRSX_BYTE_ZERO);
				to_mem = (op == MRSX_OP_DSZ);
				to_acc = (op == MRSX_OP_DSZ_A);
			end
			MRSX_OP_ISZ, MRSX_OP_ISZ_A: begin
				result = mem + `MRSX_ONE; // see RULE16 see RULE17
				skip = (result == `MRSX_BYTE_ZERO);
				to_mem = (op == MRSX_OP_ISZ);
				to_acc = (op == MRSX_OP_ISZ_A);
			end
			MRSX_OP_BIT_SKIP: begin
				skip = |(mem & bit_mask); // see RULE19
			end
			MRSX_OP_SET_BYTE: begin
				result = `MRSX_BYTE_ONES; // see RULE20
				to_mem = 1'b1;
			end
			MRSX_OP_SET_BIT: begin
				result = mem | bit_mask; // see RULE20
				to_mem = 1'b1;
			end
			MRSX_OP_SWAP: begin
				result = {mem[3:0], mem[7:4]}; // see RULE23
				to_mem = 1'b1;
			end
			default: begin
				result = acc;
			end
		endcase
		// Signed overflow: operands differ in sign and result sign follows the subtrahend
		ovf_out = (acc[`MRSX_MSB] ^ sub_b[`MRSX_MSB]) & (diff[`MRSX_MSB] ^ acc[`MRSX_MSB]);
		zero_out = (diff[7:0] == `MRSX_BYTE_ZERO); // see RULE24
		half_out = ~low_diff[`MRSX_HC_BIT];
	end
endmodule

/* File: src/mrsx_core.sv */
// Execution core for return, rotate, subtract, skip, set and swap instructions
`timescale 1ns/1ps
`include "mrsx_consts.svh"
module mrsx_core #(
	parameter int PC_W = 13,
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Instruction from fetch
	input wire logic instr_valid,
	input wire mrsx_pkg::mrsx_op_t instr_op,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_literal,
	input wire logic [7:0] mem_rdata,
	input wire logic [PC_W-1:0] call_target,
	input wire logic call_req,
	// Interrupt request, level from same clock
	input wire logic irq_pending,
	// Data memory write
	output logic mem_we,
	output logic [7:0] mem_wdata,
	// Architectural state
	output logic [7:0] acc,
	output logic flag_carry,
	output logic signed_range_flag,
	output logic flag_zero,
	output logic half_carry_flag,
	output logic global_irq_enable,
	output logic [PC_W-1:0] pc,
	// Pipeline control
	output logic busy,
	output logic irq_taken
);
	import mrsx_pkg::*;

	typedef struct packed {
		logic [7:0] acc;
		logic c;
		logic ov;
		logic z;
		logic ac;
		logic gie;
		logic [PC_W-1:0] pc;
		mrsx_state_t st;
		logic we;
		logic [7:0] wdata;
		logic irq_tk;
	} mrsx_core_t;

	mrsx_core_t s_ff;
	mrsx_core_t nxt_s;

	logic [7:0] alu_res;
	logic alu_to_acc;
	logic alu_to_mem;
	logic alu_c_we;
	logic alu_ar_we;
	logic alu_c;
	logic alu_ov;
	logic alu_z;
	logic alu_ac;
	logic alu_skip;
	logic exec;
	logic ret_op;
	logic irq_enter;

	mrsx_stack_if #(.PC_W(PC_W)) stk ();

	mrsx_stack #(
		.PC_W(PC_W),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk(clk),
		.reset_n(reset_n),
		.st(stk)
	);

	mrsx_alu u_alu (
		.op(instr_op),
		.acc(s_ff.acc),
		.mem(mem_rdata),
		.literal(instr_literal),
		.bit_sel(instr_bit),
		.carry_in(s_ff.c),
		.result(alu_res),
		.to_acc(alu_to_acc),
		.to_mem(alu_to_mem),
		.carry_we(alu_c_we),
		.arith_we(alu_ar_we),
		.carry_out(alu_c),
		.ovf_out(alu_ov),
		.zero_out(alu_z),
		.half_out(alu_ac),
		.skip(alu_skip)
	);

	// Dummy cycle swallows any instruction presented while busy
	assign exec = instr_valid && (s_ff.st == MRSX_ST_EXEC);
	assign ret_op = exec && ((instr_op == MRSX_OP_RET_LIT) || (instr_op == MRSX_OP_IRQ_EXIT));
	// A call pushes the return address; returns pop it
	// Entering the handler from an exit keeps the popped address as its return point
	assign irq_enter = exec && (instr_op == MRSX_OP_IRQ_EXIT) && irq_pending;
	assign stk.push = (exec && call_req && !ret_op) || irq_enter;
	assign stk.push_data = irq_enter ? stk.top_data : s_ff.pc + PC_W'(1);
	assign stk.pop = ret_op;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.we = 1'b0;
		nxt_s.wdata = s_ff.wdata;
		nxt_s.irq_tk = 1'b0;
		case (s_ff.st)
			MRSX_ST_EXEC: begin
				if (instr_valid) begin
					nxt_s.pc = s_ff.pc + PC_W'(1); // see RULE24
					if (call_req) begin
						nxt_s.pc = call_target;
					end
					if (instr_op == MRSX_OP_RET_LIT || instr_op == MRSX_OP_IRQ_EXIT) begin
						nxt_s.pc = stk.top_data; // see RULE1 see RULE2
					end
					if (instr_op == MRSX_OP_IRQ_EXIT) begin
						nxt_s.gie = 1'b1; // see RULE2
					end
					if (alu_to_acc) begin
						nxt_s.acc = alu_res;
					end
					if (alu_to_mem) begin
						nxt_s.we = 1'b1;
						nxt_s.wdata = alu_res;
					end
					if (alu_c_we) begin
						nxt_s.c = alu_c;
					end
					if (alu_ar_we) begin
						nxt_s.ov = alu_ov;
						nxt_s.z = alu_z;
						nxt_s.ac = alu_ac;
					end
					if (alu_skip) begin
						nxt_s.st = MRSX_ST_DUMMY; // see RULE18
					end
					// Pending request is taken right after the exit, before the main program
					if (instr_op == MRSX_OP_IRQ_EXIT && irq_pending) begin
						nxt_s.pc = PC_W'(`MRSX_IRQ_VECTOR); // see RULE3
						nxt_s.gie = 1'b0;
						nxt_s.irq_tk = 1'b1;
					end
				end
			end
			MRSX_ST_DUMMY: begin
				// Skipped instruction is fetched but not executed
				nxt_s.pc = s_ff.pc + PC_W'(1); // see RULE18
				nxt_s.st = MRSX_ST_EXEC;
			end
			default: begin
				nxt_s.st = MRSX_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '{acc: 8'h00, c: 1'b0, ov: 1'b0, z: 1'b0, ac: 1'b0, gie: 1'b0,
				pc: PC_W'(`MRSX_PC_RST), st: MRSX_ST_EXEC, we: 1'b0, wdata: 8'h00,
				irq_tk: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign acc = s_ff.acc;
	assign flag_carry = s_ff.c;
	assign signed_range_flag = s_ff.ov;
	assign flag_zero = s_ff.z;
	assign half_carry_flag = s_ff.ac;
	assign global_irq_enable = s_ff.gie;
	assign pc = s_ff.pc;
	assign mem_we = s_ff.we;
	assign mem_wdata = s_ff.wdata;
	assign busy = (s_ff.st == MRSX_ST_DUMMY);
	assign irq_taken = s_ff.irq_tk;

	// Returns and interrupt exit
	a_retlit_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
		exec && instr_op == MRSX_OP_RET_LIT |=>
		acc == $past(instr_literal) && pc == $past(stk.top_data) &&
		flag_carry == $past(flag_carry) && flag_zero == $past(flag_zero))
		else $error("literal return did not load accumulator");
	a_exit_gie: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
		exec && instr_op == MRSX_OP_IRQ_EXIT && !irq_pending |=>
		global_irq_enable && pc == $past(stk.top_data))
		else $error("interrupt exit did not enable interrupts");
	a_exit_pend: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
		exec && instr_op == MRSX_OP_IRQ_EXIT && irq_pending |=>
		irq_taken && pc == PC_W'(`MRSX_IRQ_VECTOR))
		else $error("pending interrupt not serviced at exit");

	// Rotates
	a_rol_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
		exec && instr_op == MRSX_OP_ROL |=>
		mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
		else $error("rotate left wrong");
	a_rol_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
		exec && instr_op == MRSX_OP_ROL_A |=>
		!mem_we && acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
		else $error("rotate left to accumulator wrong");
	a_rolc_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
		exec && instr_op == MRSX_OP_ROLC |=> mem_we && flag_carry == $past(mem_rdata[7]) &&
		mem_wdata == {$past(mem_rdata[6:0]), $past(flag_carry)})
		else $error("rotate left through carry wrong");
	a_rolc_carry: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
		exec && instr_op == MRSX_OP_ROLC_A |=> flag_carry == $past(mem_rdata[7]) && !mem_we &&
		acc == {$past(mem_rdata[6:0]), $past(flag_carry)})
		else $error("rotate through carry wrong");
	a_ror_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE8
		exec && instr_op == MRSX_OP_ROR |=>
		mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
		else $error("rotate right wrong");
	a_ror_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE9
		exec && instr_op == MRSX_OP_ROR_A |=>
		!mem_we && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
		else $error("rotate right to accumulator wrong");
	a_rorc_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE10
		exec && instr_op == MRSX_OP_RORC |=> mem_we && flag_carry == $past(mem_rdata[0]) &&
		mem_wdata == {$past(flag_carry), $past(mem_rdata[7:1])})
		else $error("rotate right through carry to memory wrong");
	a_rorc_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE11
		exec && instr_op == MRSX_OP_RORC_A |=> !mem_we && flag_carry == $past(mem_rdata[0]) &&
		acc == {$past(flag_carry), $past(mem_rdata[7:1])})
		else $error("rotate right through carry wrong");

	// Subtractions
	a_sbc_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE12
		exec && instr_op == MRSX_OP_SBC_A |=> !mem_we &&
		acc == 8'($past(acc) - $past(mem_rdata) - {7'h00, !$past(flag_carry)}))
		else $error("subtract with borrow wrong");
	a_sbc_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE13
		exec && instr_op == MRSX_OP_SBC_M |=> mem_we && acc == $past(acc) &&
		mem_wdata == 8'($past(acc) - $past(mem_rdata) - {7'h00, !$past(flag_carry)}))
		else $error("subtract with borrow to memory wrong");
	a_sub_carry: assert property (@(posedge clk) disable iff (!reset_n) // see RULE21
		exec && instr_op == MRSX_OP_SUB_A |=>
		flag_carry == ($past(acc) >= $past(mem_rdata)))
		else $error("subtract carry wrong");
	a_difference_to_mem_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE21
		exec && instr_op == MRSX_OP_SUB_M |=> mem_we && acc == $past(acc) &&
		mem_wdata == 8'($past(acc) - $past(mem_rdata)))
		else $error("subtract to memory wrong");
	a_subi_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE22
		exec && instr_op == MRSX_OP_SUB_IMM |=> acc == 8'($past(acc) - $past(instr_literal)) &&
		flag_carry == ($past(acc) >= $past(instr_literal)))
		else $error("immediate subtract wrong");
	a_sub_zero: assert property (@(posedge clk) disable iff (!reset_n) // see RULE24
		exec && instr_op == MRSX_OP_SUB_IMM |=>
		flag_zero == ($past(acc) == $past(instr_literal)))
		else $error("zero flag wrong");

	// Skips, sets and swap
	a_dsz_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE14
		exec && instr_op == MRSX_OP_DSZ |=> mem_we && busy == ($past(mem_rdata) == 8'h01) &&
		mem_wdata == 8'($past(mem_rdata) - 8'h01))
		else $error("decrement skip wrong");
	a_dsz_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE15
		exec && instr_op == MRSX_OP_DSZ_A |=> !mem_we && busy == ($past(mem_rdata) == 8'h01) &&
		acc == 8'($past(mem_rdata) - 8'h01))
		else $error("decrement skip to accumulator wrong");
	a_isz_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE16
		exec && instr_op == MRSX_OP_ISZ |=> mem_we && busy == ($past(mem_rdata) == 8'hFF) &&
		mem_wdata == 8'($past(mem_rdata) + 8'h01))
		else $error("increment skip wrong");
	a_isz_acc: assert property (@(posedge clk) disable iff (!reset_n) // see RULE17
		exec && instr_op == MRSX_OP_ISZ_A |=> !mem_we && busy == ($past(mem_rdata) == 8'hFF) &&
		acc == 8'($past(mem_rdata) + 8'h01))
		else $error("increment skip to accumulator wrong");
	a_skip_dummy: assert property (@(posedge clk) disable iff (!reset_n) // see RULE18
		exec && alu_skip |=>
		busy ##1 !busy)
		else $error("skip did not take two cycles");
	a_bit_skip: assert property (@(posedge clk) disable iff (!reset_n) // see RULE19
		exec && instr_op == MRSX_OP_BIT_SKIP |=>
		!mem_we && busy == $past(mem_rdata[instr_bit]))
		else $error("bit test skip wrong");
	a_set_byte: assert property (@(posedge clk) disable iff (!reset_n) // see RULE20
		exec && instr_op == MRSX_OP_SET_BYTE |=>
		mem_we && mem_wdata == 8'hFF && flag_carry == $past(flag_carry))
		else $error("byte set wrong");
	a_set_bit: assert property (@(posedge clk) disable iff (!reset_n) // see RULE20
		exec && instr_op == MRSX_OP_SET_BIT |=>
		mem_we && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(instr_bit))))
		else $error("bit set wrong");
	a_swap_mem: assert property (@(posedge clk) disable iff (!reset_n) // see RULE23
		exec && instr_op == MRSX_OP_SWAP |=>
		mem_we && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
		else $error("nibble swap wrong");

	c_skip: cover property (@(posedge clk) disable iff (!reset_n) exec && alu_skip);
	c_refused: cover property (@(posedge clk) disable iff (!reset_n) busy && instr_valid);
	c_exit_irq: cover property (@(posedge clk) disable iff (!reset_n) irq_taken);
	c_sbc_neg: cover property (@(posedge clk) disable iff (!reset_n)
		exec && instr_op == MRSX_OP_SBC_A && !alu_c);
endmodule

/* File: src/mrsx_stack.sv */
// Return address stack, top of stack read from the entry array at the current count minus one
`timescale 1ns/1ps
`include "mrsx_consts.svh"
module mrsx_stack #(
	parameter int PC_W = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Stack port
	mrsx_stack_if.stack st
);
	localparam int PW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][PC_W-1:0] mem;
		logic [PW-1:0] cnt;
	} mrsx_stk_t;
	mrsx_stk_t stk_ff;
	mrsx_stk_t nxt_stk;

	always_comb begin
		nxt_stk = stk_ff;
		// Overflow writes the pushed address over the oldest entry while the count holds at DEPTH
		if (st.push && st.pop && stk_ff.cnt != '0) begin
			// Push with pop replaces the top entry, so the depth stays as it was
			nxt_stk.mem[(stk_ff.cnt - PW'(1)) % PW'(DEPTH)] = st.push_data;
		end else if (st.push) begin
			nxt_stk.mem[stk_ff.cnt % PW'(DEPTH)] = st.push_data;
			if (stk_ff.cnt != PW'(DEPTH)) begin
				nxt_stk.cnt = stk_ff.cnt + PW'(1);
			end
		end else if (st.pop && stk_ff.cnt != '0) begin
			nxt_stk.cnt = stk_ff.cnt - PW'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stk_ff <= '0;
		end else begin
			stk_ff <= nxt_stk;
		end
	end

	assign st.top_data = (stk_ff.cnt == '0) ? PC_W'(`MRSX_PC_RST) :
		stk_ff.mem[(stk_ff.cnt - PW'(1)) % PW'(DEPTH)];
	assign st.empty = (stk_ff.cnt == '0);
endmodule
